/* File: pfm_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// external rom and ram seen from the pins
module pfm_ext_mem (
    input wire logic clock_in,
    input wire logic sep_in,
    input wire logic [7:0] p0_pin_out,
    input wire logic [7:0] p2_pin_out,
    input wire logic [7:0] p3_pin_out,
    input wire logic [7:0] p4_pin_out,
    input wire logic [7:0] p4_pin_oe_out,
    input wire logic addr_ctrl_out,
    input wire logic ext_rom_out_en_n,
    output logic drv_en_out,
    output logic [7:0] drv_out
);
logic [15:0] addr = 16'h0000;
logic [7:0] ram [0:255];
wire rd_lo = p4_pin_oe_out[6] && !p4_pin_out[6];
wire wr_lo = p4_pin_oe_out[7] && !p4_pin_out[7];
always @(posedge clock_in)
begin
    if (addr_ctrl_out)
        addr <= {p2_pin_out, sep_in ? p3_pin_out : p0_pin_out};
    if (wr_lo)
        ram[addr[7:0]] <= p0_pin_out;
end
// released bus: bench pull-up shows
always_comb
begin
    drv_en_out = !ext_rom_out_en_n || rd_lo;
    drv_out = ext_rom_out_en_n ? ram[addr[7:0]] :
        addr[7:0] ^ addr[15:8] ^ 8'hA5;
end
endmodule // pfm_ext_mem
`default_nettype wire

/* File: pfm_key_irq.v */
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
// ==========================================================
// key interrupt: one pulse when any watched pin falls low
module pfm_key_irq (
    input wire clock_in,
    input wire rst_b_in,
    input wire enable_in,
    input wire [7:0] level_in,
    output reg key_pulse_out
);
    reg [7:0] prev;
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            prev <= `PFM_RST_BYTE;
            key_pulse_out <= `PFM_RST_BIT;
        end
        else
        begin
            prev <= level_in;
            key_pulse_out <= enable_in & (|(prev & ~level_in));
        end
    end
endmodule // pfm_key_irq
`default_nettype wire

/* File: pfm_map.vh */
`ifndef PFM_MAP_VH
`define PFM_MAP_VH
// ==========================================================
// register byte addresses
`define PFM_A_P0_DATA 8'h00
`define PFM_A_P0_DIR 8'h04
`define PFM_A_P1_DATA 8'h08
`define PFM_A_P1_DIR 8'h0C
`define PFM_A_P2_DATA 8'h10
`define PFM_A_P2_DIR 8'h14
`define PFM_A_P3_DATA 8'h18
`define PFM_A_P3_DIR 8'h1C
`define PFM_A_P4_DATA 8'h20
`define PFM_A_P4_DIR 8'h24
`define PFM_A_EXT_CTRL 8'h28
`define PFM_A_P1_ALT 8'h2C
`define PFM_A_P4_ALT 8'h30
`define PFM_A_P3_IRQ_CTRL 8'h34
`define PFM_A_PINS_LO 8'h38
`define PFM_A_PINS_P4 8'h3C
`define PFM_A_IRQ_STAT 8'h40
`define PFM_A_IRQ_CLR 8'h44
`define PFM_A_IRQ_EN 8'h48
// ==========================================================
// field positions
`define PFM_EXT_EN_BIT 0
`define PFM_EXT_SEP_BIT 2
`define PFM_KEY_SEL_BIT 0
`define PFM_P4_LCD_BIT 0
`define PFM_P4_RAM_BIT 1
`define PFM_IRQ_KEY_BIT 0
`define PFM_IRQ_DONE_BIT 1
`define PFM_RD_PIN 6
`define PFM_WR_PIN 7
// ==========================================================
// reset values and timing
`define PFM_RST_BYTE 8'h00
`define PFM_RST_PAIR 2'h0
`define PFM_RST_BIT 1'h0
`define PFM_ONES_BYTE 8'hFF
`define PFM_ZERO_WORD 32'h0000_0000
`define PFM_DATA_CYC 3'h3
`define PFM_CNT_ZERO 3'h0
`define PFM_CNT_ONE 3'h1
`endif

/* File: pfm_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
// ==========================================================
// one 8-pin port: per-pin choice of general or alternate
// drive, registered pad outputs and registered pad sampling
module pfm_port (
    input wire clock_in,
    input wire rst_b_in,
    input wire [7:0] gp_out_in,
    input wire [7:0] gp_oe_in,
    input wire [7:0] alt_sel_in,
    input wire [7:0] alt_out_in,
    input wire [7:0] alt_oe_in,
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe_out,
    output reg [7:0] din_out
);
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            pin_out <= `PFM_RST_BYTE;
            pin_oe_out <= `PFM_RST_BYTE;
            din_out <= `PFM_RST_BYTE;
        end
        else
        begin
            pin_out <= (alt_sel_in & alt_out_in) | (~alt_sel_in & gp_out_in);
            pin_oe_out <= (alt_sel_in & alt_oe_in) | (~alt_sel_in & gp_oe_in);
            din_out <= pin_in;
        end
    end
endmodule // pfm_port
`default_nettype wire

/* File: pfm_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
module pfm_props (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic [15:0] ext_addr_in,
    input wire logic ext_busy_out,
    input wire logic ext_done_out,
    input wire logic [7:0] p0_pin_out,
    input wire logic [7:0] p0_pin_oe_out,
    input wire logic [7:0] p2_pin_out,
    input wire logic [7:0] p2_pin_oe_out,
    input wire logic [7:0] p3_pin_out,
    input wire logic [7:0] p3_pin_oe_out,
    input wire logic addr_ctrl_out,
    input wire logic ext_rom_out_en_n,
    input wire logic irq_out
);
default clocking @(posedge clock_in); endclocking
default disable iff (!rst_b_in);
// ======
// external access
property p_rst_idle;
    disable iff (1'b0) !rst_b_in |=> ext_rom_out_en_n && !ext_busy_out
        && (p0_pin_oe_out | p2_pin_oe_out | p3_pin_oe_out) == 8'h00;
endproperty
property p_done_lat;
    $rose(ext_busy_out) |-> ##[4:7] ext_done_out;
endproperty
property p_addr_ctrl_out;
    addr_ctrl_out |-> ext_busy_out ##1 !addr_ctrl_out;
endproperty
property p_rom_len;
    $fell(ext_rom_out_en_n) |-> !ext_rom_out_en_n[*3] ##1 ext_rom_out_en_n;
endproperty
property p_rom_busy;
    !ext_rom_out_en_n |-> ext_busy_out && !addr_ctrl_out;
endproperty
property p_hi_addr;
    addr_ctrl_out || !ext_rom_out_en_n |->
        p2_pin_oe_out == 8'hFF && p2_pin_out == ext_addr_in[15:8];
endproperty
property p_lo_addr;
    addr_ctrl_out |->
        (p0_pin_oe_out == 8'hFF && p0_pin_out == ext_addr_in[7:0]) ||
        (p3_pin_oe_out == 8'hFF && p3_pin_out == ext_addr_in[7:0]);
endproperty
// ======
// interrupt
property p_irq_mask;
    psel_in && penable_in && pready_out && pwrite_in &&
        paddr_in == `PFM_A_IRQ_EN && pwdata_in[1:0] == 2'b00
        |-> ##2 !irq_out;
endproperty
a_rst_idle: assert property (p_rst_idle)
    else $error("pins not idle under reset");
a_done_lat: assert property (p_done_lat)
    else $error("access did not finish in time");
a_addr_ctrl_out: assert property (p_addr_ctrl_out)
    else $error("address control not a single pulse");
a_rom_len: assert property (p_rom_len)
    else $error("rom enable low for wrong length");
a_rom_busy: assert property (p_rom_busy)
    else $error("rom enable outside data phase");
a_hi_addr: assert property (p_hi_addr)
    else $error("port two not driving high address");
a_lo_addr: assert property (p_lo_addr)
    else $error("low address missing on pins");
a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt stayed high when masked");
c_rom: cover property ($fell(ext_rom_out_en_n));
c_sep: cover property (addr_ctrl_out && p3_pin_oe_out == 8'hFF);
c_irq: cover property ($rose(irq_out));
endmodule // pfm_props
bind pfm_top pfm_props u_props (.*);
`default_nettype wire

/* File: pfm_top.v */
// Behaviour
// (RQ1) port zero direction set per nibble
// (RQ2) separate bit clear: port zero muxes address/data
// (RQ3) separate bit set: port three drives low address
// (RQ4) port two drives high address byte
// (RQ5) port four direction: upper two, lower six
// (RQ6) port four pins 6/7: RAM read/write strobes
// (RQ7) port four pins 0-3: LCD expansion outputs
// (RQ8) port one: serial, buzzer, PWM alternates
// (RQ9) port zero keys interrupt when select zero; code also blocks it in external mode with separate bit clear
// (RQ10) key select is interrupt control bit zero
// (RQ11) drive address control and ROM enable low
// (RQ12) reset: all inputs, external mode off
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
module pfm_top (
    input wire clock_in,
    input wire rst_b_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire ext_req_in,
    input wire ext_rom_in,
    input wire ext_we_in,
    input wire [15:0] ext_addr_in,
    input wire [7:0] ext_wdata_in,
    output reg [7:0] ext_rdata_out,
    output reg ext_busy_out,
    output reg ext_done_out,
    input wire [7:0] p1_alt_out_in,
    input wire [7:0] p1_alt_oe_in,
    input wire [3:0] lcd_exp_in,
    output reg [7:0] p1_alt_din_out,
    input wire [7:0] p0_pin_in,
    output wire [7:0] p0_pin_out,
    output wire [7:0] p0_pin_oe_out,
    input wire [7:0] p1_pin_in,
    output wire [7:0] p1_pin_out,
    output wire [7:0] p1_pin_oe_out,
    input wire [7:0] p2_pin_in,
    output wire [7:0] p2_pin_out,
    output wire [7:0] p2_pin_oe_out,
    input wire [7:0] p3_pin_in,
    output wire [7:0] p3_pin_out,
    output wire [7:0] p3_pin_oe_out,
    input wire [7:0] p4_pin_in,
    output wire [7:0] p4_pin_out,
    output wire [7:0] p4_pin_oe_out,
    output reg addr_ctrl_out,
    output reg ext_rom_out_en_n,
    output reg irq_out
);
    localparam ST_IDLE = 4'h1;
    localparam ST_ADDR = 4'h2;
    localparam ST_DATA = 4'h4;
    localparam ST_DONE = 4'h8;

    // ======================================================
    // software registers
    reg [7:0] p0_dat;
    reg [1:0] p0_dir;
    reg [7:0] p1_dat;
    reg [7:0] p1_dir;
    reg [7:0] p2_dat;
    reg [7:0] p2_dir;
    reg [7:0] p3_dat;
    reg [7:0] p3_dir;
    reg [7:0] p4_dat;
    reg [1:0] p4_dir;
    reg [7:0] ext_mem_ctrl;
    reg [7:0] p1_alt;
    reg [1:0] p4_alt;
    reg [7:0] port3_irq_ctrl;
    reg [1:0] irq_stat;
    reg [1:0] irq_en;

    // ======================================================
    // external access sequencer state
    reg [3:0] state;
    reg [3:0] next_state;
    reg [2:0] cnt;
    reg [15:0] acc_addr;
    reg [7:0] acc_wdata;
    reg acc_rom;
    reg acc_we;

    wire [7:0] p0_din;
    wire [7:0] p1_din;
    wire [7:0] p2_din;
    wire [7:0] p3_din;
    wire [7:0] p4_din;
    wire key_pulse;
    wire ext_on;
    wire ext_sep;
    wire key_sel;
    wire wr_en;
    wire setup;
    wire done_evt;
    wire [1:0] irq_set;
    wire [1:0] next_stat;

    assign ext_on = ext_mem_ctrl[`PFM_EXT_EN_BIT];
    assign ext_sep = ext_mem_ctrl[`PFM_EXT_SEP_BIT];
    assign key_sel = port3_irq_ctrl[`PFM_KEY_SEL_BIT]; // RQ10
    assign setup = psel_in & ~penable_in;
    assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
    assign done_evt = (state == ST_DONE);

    // ======================================================
    // apb slave: answers in the first access cycle
    reg [31:0] rd_mux;
    reg hit;
    always @*
    begin
        rd_mux = `PFM_ZERO_WORD;
        hit = 1'b1;
        if (paddr_in == `PFM_A_P0_DATA)
            rd_mux[7:0] = p0_dat;
        else if (paddr_in == `PFM_A_P0_DIR)
            rd_mux[1:0] = p0_dir;
        else if (paddr_in == `PFM_A_P1_DATA)
            rd_mux[7:0] = p1_dat;
        else if (paddr_in == `PFM_A_P1_DIR)
            rd_mux[7:0] = p1_dir;
        else if (paddr_in == `PFM_A_P2_DATA)
            rd_mux[7:0] = p2_dat;
        else if (paddr_in == `PFM_A_P2_DIR)
            rd_mux[7:0] = p2_dir;
        else if (paddr_in == `PFM_A_P3_DATA)
            rd_mux[7:0] = p3_dat;
        else if (paddr_in == `PFM_A_P3_DIR)
            rd_mux[7:0] = p3_dir;
        else if (paddr_in == `PFM_A_P4_DATA)
            rd_mux[7:0] = p4_dat;
        else if (paddr_in == `PFM_A_P4_DIR)
            rd_mux[1:0] = p4_dir;
        else if (paddr_in == `PFM_A_EXT_CTRL)
            rd_mux[7:0] = ext_mem_ctrl;
        else if (paddr_in == `PFM_A_P1_ALT)
            rd_mux[7:0] = p1_alt;
        else if (paddr_in == `PFM_A_P4_ALT)
            rd_mux[1:0] = p4_alt;
        else if (paddr_in == `PFM_A_P3_IRQ_CTRL)
            rd_mux[7:0] = port3_irq_ctrl;
        else if (paddr_in == `PFM_A_PINS_LO)
            rd_mux = {p3_din, p2_din, p1_din, p0_din};
        else if (paddr_in == `PFM_A_PINS_P4)
            rd_mux[7:0] = p4_din;
        else if (paddr_in == `PFM_A_IRQ_STAT)
            rd_mux[1:0] = irq_stat;
        else if (paddr_in == `PFM_A_IRQ_CLR)
            rd_mux = `PFM_ZERO_WORD;
        else if (paddr_in == `PFM_A_IRQ_EN)
            rd_mux[1:0] = irq_en;
        else
            hit = 1'b0;
    end

    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            pready_out <= `PFM_RST_BIT;
            pslverr_out <= `PFM_RST_BIT;
            prdata_out <= `PFM_ZERO_WORD;
        end
        else
        begin
            pready_out <= setup;
            pslverr_out <= setup & ~hit;
            if (setup && !pwrite_in)
                prdata_out <= rd_mux;
            else if (!psel_in)
                prdata_out <= `PFM_ZERO_WORD;
        end
    end

    // ======================================================
    // register writes
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            p0_dat <= `PFM_RST_BYTE;
            p0_dir <= `PFM_RST_PAIR; // RQ12
            p1_dat <= `PFM_RST_BYTE;
            p1_dir <= `PFM_RST_BYTE; // RQ12
            p2_dat <= `PFM_RST_BYTE;
            p2_dir <= `PFM_RST_BYTE; // RQ12
            p3_dat <= `PFM_RST_BYTE;
            p3_dir <= `PFM_RST_BYTE; // RQ12
            p4_dat <= `PFM_RST_BYTE;
            p4_dir <= `PFM_RST_PAIR; // RQ12
            ext_mem_ctrl <= `PFM_RST_BYTE; // RQ12
            p1_alt <= `PFM_RST_BYTE; // RQ12
            p4_alt <= `PFM_RST_PAIR; // RQ12
            port3_irq_ctrl <= `PFM_RST_BYTE;
            irq_en <= `PFM_RST_PAIR;
        end
        else if (wr_en)
        begin
            if (paddr_in == `PFM_A_P0_DATA)
                p0_dat <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P0_DIR)
                p0_dir <= pwdata_in[1:0]; // RQ1
            else if (paddr_in == `PFM_A_P1_DATA)
                p1_dat <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P1_DIR)
                p1_dir <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P2_DATA)
                p2_dat <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P2_DIR)
                p2_dir <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P3_DATA)
                p3_dat <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P3_DIR)
                p3_dir <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P4_DATA)
                p4_dat <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P4_DIR)
                p4_dir <= pwdata_in[1:0]; // RQ5
            else if (paddr_in == `PFM_A_EXT_CTRL)
                ext_mem_ctrl <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P1_ALT)
                p1_alt <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_P4_ALT)
                p4_alt <= pwdata_in[1:0];
            else if (paddr_in == `PFM_A_P3_IRQ_CTRL)
                port3_irq_ctrl <= pwdata_in[7:0];
            else if (paddr_in == `PFM_A_IRQ_EN)
                irq_en <= pwdata_in[1:0];
        end
    end

    // ======================================================
    // interrupt status: a new event beats a clear
    assign irq_set = {done_evt, key_pulse};
    assign next_stat = irq_set | (irq_stat &
        ~((wr_en && paddr_in == `PFM_A_IRQ_CLR) ? pwdata_in[1:0]
                                                 : `PFM_RST_PAIR));
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            irq_stat <= `PFM_RST_PAIR;
            irq_out <= `PFM_RST_BIT;
        end
        else
        begin
            irq_stat <= next_stat;
            irq_out <= |(next_stat & irq_en);
        end
    end

    // ======================================================
    // external memory sequencer
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (ext_req_in && ext_on)
                    next_state = ST_ADDR;
            ST_ADDR:
                next_state = ST_DATA;
            ST_DATA:
                if (cnt == `PFM_CNT_ONE)
                    next_state = ST_DONE;
            ST_DONE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state <= ST_IDLE;
            cnt <= `PFM_CNT_ZERO;
            acc_addr <= {`PFM_RST_BYTE, `PFM_RST_BYTE};
            acc_wdata <= `PFM_RST_BYTE;
            acc_rom <= `PFM_RST_BIT;
            acc_we <= `PFM_RST_BIT;
            ext_rdata_out <= `PFM_RST_BYTE;
            ext_busy_out <= `PFM_RST_BIT;
            ext_done_out <= `PFM_RST_BIT;
            addr_ctrl_out <= `PFM_RST_BIT;
            ext_rom_out_en_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && next_state == ST_ADDR)
            begin
                acc_addr <= ext_addr_in;
                acc_wdata <= ext_wdata_in;
                acc_rom <= ext_rom_in;
                acc_we <= ext_we_in & ~ext_rom_in;
            end
            if (state == ST_ADDR)
                cnt <= `PFM_DATA_CYC;
            else if (cnt != `PFM_CNT_ZERO)
                cnt <= cnt - `PFM_CNT_ONE;
            // pad sample lags by one; last data cycle sees settled bus
            if (state == ST_DATA && cnt == `PFM_CNT_ONE && !acc_we)
                ext_rdata_out <= p0_din;
            ext_busy_out <= (next_state != ST_IDLE);
            ext_done_out <= done_evt;
            addr_ctrl_out <= (state == ST_ADDR); // RQ11
            ext_rom_out_en_n <= ~(state == ST_DATA && acc_rom); // RQ11
        end
    end

    // ======================================================
    // pin function selection
    reg [7:0] p0_sel;
    reg [7:0] p0_aout;
    reg [7:0] p0_aoe;
    reg [7:0] p4_sel;
    reg [7:0] p4_aout;
    reg [7:0] p4_aoe;
    wire busy_bus;
    assign busy_bus = (state != ST_IDLE);
    always @*
    begin
        p0_sel = ext_on ? `PFM_ONES_BYTE : `PFM_RST_BYTE;
        p0_aout = `PFM_RST_BYTE;
        p0_aoe = `PFM_RST_BYTE;
        if (state == ST_ADDR && !ext_sep)
        begin
            p0_aout = acc_addr[7:0]; // RQ2
            p0_aoe = `PFM_ONES_BYTE; // RQ2
        end
        else if (state == ST_DATA && acc_we)
        begin
            p0_aout = acc_wdata; // RQ2 RQ3
            p0_aoe = `PFM_ONES_BYTE;
        end
        p4_sel = `PFM_RST_BYTE;
        p4_aout = `PFM_RST_BYTE;
        p4_aoe = `PFM_RST_BYTE;
        if (p4_alt[`PFM_P4_LCD_BIT])
        begin
            p4_sel[3:0] = 4'hF; // RQ7
            p4_aout[3:0] = lcd_exp_in; // RQ7
            p4_aoe[3:0] = 4'hF;
        end
        if (p4_alt[`PFM_P4_RAM_BIT])
        begin
            p4_sel[`PFM_WR_PIN:`PFM_RD_PIN] = 2'h3;
            p4_aoe[`PFM_WR_PIN:`PFM_RD_PIN] = 2'h3;
            p4_aout[`PFM_RD_PIN] = ~(state == ST_DATA && !acc_rom
                                   && !acc_we); // RQ6
            p4_aout[`PFM_WR_PIN] = ~(state == ST_DATA && acc_we); // RQ6
        end
    end

    // ======================================================
    // ports
    pfm_port u_port0 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .gp_out_in(p0_dat),
        .gp_oe_in({{4{p0_dir[1]}}, {4{p0_dir[0]}}}), // RQ1
        .alt_sel_in(p0_sel),
        .alt_out_in(p0_aout),
        .alt_oe_in(p0_aoe),
        .pin_in(p0_pin_in),
        .pin_out(p0_pin_out),
        .pin_oe_out(p0_pin_oe_out),
        .din_out(p0_din)
    );
    pfm_port u_port1 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .gp_out_in(p1_dat),
        .gp_oe_in(p1_dir),
        .alt_sel_in(p1_alt), // RQ8
        .alt_out_in(p1_alt_out_in),
        .alt_oe_in(p1_alt_oe_in),
        .pin_in(p1_pin_in),
        .pin_out(p1_pin_out),
        .pin_oe_out(p1_pin_oe_out),
        .din_out(p1_din)
    );
    pfm_port u_port2 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .gp_out_in(p2_dat),
        .gp_oe_in(p2_dir),
        .alt_sel_in(ext_on ? `PFM_ONES_BYTE : `PFM_RST_BYTE),
        .alt_out_in(acc_addr[15:8]), // RQ4
        .alt_oe_in(`PFM_ONES_BYTE), // RQ4
        .pin_in(p2_pin_in),
        .pin_out(p2_pin_out),
        .pin_oe_out(p2_pin_oe_out),
        .din_out(p2_din)
    );
    pfm_port u_port3 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .gp_out_in(p3_dat),
        .gp_oe_in(p3_dir),
        .alt_sel_in((ext_on && ext_sep) ? `PFM_ONES_BYTE
                                         : `PFM_RST_BYTE), // RQ3
        .alt_out_in(acc_addr[7:0]), // RQ3
        .alt_oe_in(`PFM_ONES_BYTE),
        .pin_in(p3_pin_in),
        .pin_out(p3_pin_out),
        .pin_oe_out(p3_pin_oe_out),
        .din_out(p3_din)
    );
    pfm_port u_port4 (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .gp_out_in(p4_dat),
        .gp_oe_in({{2{p4_dir[1]}}, {6{p4_dir[0]}}}), // RQ5
        .alt_sel_in(p4_sel),
        .alt_out_in(p4_aout),
        .alt_oe_in(p4_aoe),
        .pin_in(p4_pin_in),
        .pin_out(p4_pin_out),
        .pin_oe_out(p4_pin_oe_out),
        .din_out(p4_din)
    );

    // serial clock/data inputs go back to the channels
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
            p1_alt_din_out <= `PFM_RST_BYTE;
        else
            p1_alt_din_out <= p1_din; // RQ8
    end

    // ======================================================
    // key interrupt; off while port zero carries addresses
    pfm_key_irq u_key (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .enable_in(~key_sel & ~(ext_on & ~ext_sep)), // RQ9
        .level_in(p0_din),
        .key_pulse_out(key_pulse)
    );
    wire unused_busy;
    assign unused_busy = busy_bus;
endmodule // pfm_top
`default_nettype wire

/* File: port_function_mux_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
module port_function_mux_bench;
logic clock_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
logic pwrite_in = 1'b0, ext_req_in = 1'b0, ext_rom_in = 1'b0;
logic ext_we_in = 1'b0, sep = 1'b0;
logic [7:0] paddr_in = 8'h00, ext_wdata_in = 8'h00, lv = 8'h00;
logic [7:0] p1_alt_out_in = 8'h00, p1_alt_oe_in = 8'h00, key = 8'hFF;
logic [31:0] pwdata_in = 32'h0000_0000, s = 32'h28c0_2127;
logic [15:0] ext_addr_in = 16'h0000, a;
logic [3:0] lcd_exp_in = 4'h0;
logic [31:0] prdata_out;
logic pready_out, pslverr_out, ext_busy_out, ext_done_out, men;
logic addr_ctrl_out, ext_rom_out_en_n, irq_out;
logic [7:0] ext_rdata_out, p1_alt_din_out, mdat, m;
logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe_out, p1_pin_in, p1_pin_out;
logic [7:0] p1_pin_oe_out, p2_pin_in, p2_pin_out, p2_pin_oe_out;
logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe_out, p4_pin_in, p4_pin_out;
logic [7:0] p4_pin_oe_out;
logic [32:0] rq[$];
logic [8:0] xq[$];
logic [8:0] xe;
int err_total = 0, n_compared = 0, cyc = 0, i;
assign p0_pin_in = (p0_pin_oe_out & p0_pin_out) |
    (~p0_pin_oe_out & (men ? mdat : key));
assign p1_pin_in = (p1_pin_oe_out & p1_pin_out) | (~p1_pin_oe_out & lv);
assign p2_pin_in = (p2_pin_oe_out & p2_pin_out) | (~p2_pin_oe_out & lv);
assign p3_pin_in = (p3_pin_oe_out & p3_pin_out) | (~p3_pin_oe_out & lv);
assign p4_pin_in = (p4_pin_oe_out & p4_pin_out) | (~p4_pin_oe_out & lv);
pfm_top uut (.*);
pfm_ext_mem mem (.*, .sep_in(sep), .drv_en_out(men), .drv_out(mdat));
// ======
// helpers
function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task automatic check(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e)
    begin
        err_total++;
        $display("mismatch at %0t seen %h expected %h", $time, g, e);
    end
endtask
task automatic pc(input logic [15:0] g, input logic [15:0] e);
    check({17'h0_0000, g}, {17'h0_0000, e});
endtask
task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d, input logic [32:0] e);
    if (!w)
        rq.push_back(e);
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do
        @(posedge clock_in);
    while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
endtask
task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0_0000_0000);
endtask
task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0000_0000, {1'b0, e});
endtask
task automatic ext(input logic r, input logic we, input logic [15:0] ad,
    input logic [7:0] d, input logic [8:0] e);
    xq.push_back(e);
    @(posedge clock_in);
    ext_req_in <= 1'b1;
    ext_rom_in <= r;
    ext_we_in <= we;
    ext_addr_in <= ad;
    ext_wdata_in <= d;
    do
        @(posedge clock_in);
    while (ext_busy_out !== 1'b1);
    ext_req_in <= 1'b0;
    do
        @(posedge clock_in);
    while (ext_done_out !== 1'b1);
endtask
task automatic settle;
    repeat (4) @(posedge clock_in);
endtask
task print_verdict;
    if (err_total == 0 && n_compared > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
// ======
// clock, monitor, hang guard
initial
begin
    forever #4 clock_in = ~clock_in;
end
always @(posedge clock_in)
begin
    if (psel_in && penable_in && pready_out && !pwrite_in)
        check({pslverr_out, prdata_out}, rq.pop_front());
    if (ext_done_out)
    begin
        xe = xq.pop_front();
        if (xe[8])
            check(ext_rdata_out, xe[7:0]);
    end
    cyc++;
    if (cyc == 5000)
    begin
        err_total++;
        print_verdict;
    end
end
// ======
// scenarios
initial
begin
    repeat (8) @(posedge clock_in);
    pc({p0_pin_oe_out | p2_pin_oe_out | p3_pin_oe_out | p4_pin_oe_out,
        ext_busy_out, ext_rom_out_en_n, irq_out, 5'h00}, 16'h0040);
    rst_b_in <= 1'b1;
    for (i = 0; i <= 8'h34; i += 4)
        rd(i[7:0], 32'h0000_0000);
    rd(`PFM_A_IRQ_STAT, 32'h0000_0000);
    apb(1'b0, 8'h4C, 32'h0000_0000, {1'b1, 32'h0000_0000});
    ext_req_in <= 1'b1;
    settle;
    check(ext_busy_out, 1'b0);
    ext_req_in <= 1'b0;
    wr(`PFM_A_P0_DATA, s);
    wr(`PFM_A_P4_DATA, s);
    for (i = 0; i < 4; i++)
    begin
        wr(`PFM_A_P0_DIR, i);
        wr(`PFM_A_P4_DIR, i);
        settle;
        m = {{4{i[1]}}, {4{i[0]}}};
        pc({p0_pin_oe_out, p0_pin_out & m}, {m, s[7:0] & m});
        m = {{2{i[1]}}, {6{i[0]}}};
        pc({p4_pin_oe_out, p4_pin_out & m}, {m, s[7:0] & m});
    end
    s = nx(s);
    wr(`PFM_A_P1_ALT, 32'h0000_00FF);
    wr(`PFM_A_P4_ALT, 32'h0000_0001);
    wr(`PFM_A_P4_DATA, s);
    p1_alt_out_in <= s[7:0];
    p1_alt_oe_in <= s[15:8];
    lv <= s[23:16];
    lcd_exp_in <= s[27:24];
    settle;
    pc({p1_pin_oe_out, p1_pin_out & s[15:8]}, {s[15:8], s[7:0] & s[15:8]});
    pc({8'h00, p1_alt_din_out},
        {8'h00, (s[15:8] & s[7:0]) | (~s[15:8] & s[23:16])});
    pc({p4_pin_oe_out, 2'b00, p4_pin_out[5:0]},
        {8'hFF, 2'b00, s[5:4], s[27:24]});
    wr(`PFM_A_P4_ALT, 32'h0000_0002);
    settle;
    pc({14'h0000, p4_pin_out[7:6] & p4_pin_oe_out[7:6]}, 16'h0003);
    for (i = 0; i < 2; i++)
    begin
        sep <= i[0];
        wr(`PFM_A_EXT_CTRL, i ? 32'h0000_0005 : 32'h0000_0001);
        s = nx(s);
        a = s[15:0];
        ext(1'b1, 1'b0, a, 8'h00, {1'b1, a[7:0] ^ a[15:8] ^ 8'hA5});
        ext(1'b0, 1'b1, a, s[23:16], 9'h000);
        ext(1'b0, 1'b0, a, 8'h00, {1'b1, s[23:16]});
    end
    wr(`PFM_A_EXT_CTRL, 32'h0000_0000);
    wr(`PFM_A_P0_DIR, 32'h0000_0000);
    wr(`PFM_A_IRQ_EN, 32'h0000_0001);
    // select one: no event; zero: event latched
    for (i = 1; i >= 0; i--)
    begin
        wr(`PFM_A_P3_IRQ_CTRL, i);
        settle;
        wr(`PFM_A_IRQ_CLR, 32'h0000_0003);
        s = nx(s);
        key <= ~(8'h01 << s[2:0]);
        settle;
        pc({15'h0000, irq_out}, {15'h0000, ~i[0]});
        rd(`PFM_A_IRQ_STAT, {31'h0000_0000, ~i[0]});
        key <= 8'hFF;
    end
    wr(`PFM_A_IRQ_EN, 32'h0000_0000);
    settle;
    check(irq_out, 1'b0);
    rd(`PFM_A_IRQ_STAT, 32'h0000_0001);
    wr(`PFM_A_IRQ_CLR, 32'h0000_0001);
    rd(`PFM_A_IRQ_STAT, 32'h0000_0000);
    rd(`PFM_A_IRQ_CLR, 32'h0000_0000);
    settle;
    print_verdict;
end
endmodule // port_function_mux_bench
`default_nettype wire
